// file: rtl/tsc_top.sv
// Touch channel configuration, sequencing, filtering and threshold logic
// Contract
// - Normal mode start write launches one sequence
// - Normal mode interrupt when duty result ready
// - Auto mode gap (sleep_start_gap+1)*2 units
// - Ignore noise longer than noise_filter_len*8
// - Cycle counter keeps running through noise
// - Low plus high duty equals cycle count
// - Relative threshold: limit plus baseline
// - sleep_noise_filter_on gates filtering in auto
// - Noise flag updates regardless of filter gate
// - Auto: duty above threshold raises irq, wakeup
// - Interrupt also sets touch_irq_flag
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module tsc_top #(
	parameter int TK_DIV = 2
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Register port
	input  wire logic [tsc_pkg::AW-1:0] reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// Analog front end
	input  wire tsc_pkg::tsc_fe_in_t   fe_in,
	output tsc_pkg::tsc_fe_out_t       fe_out,
	// Events
	output logic                       irq,
	output logic                       wakeup
);
	import tsc_pkg::*;

	// ------------------------------------------------------------
	// Registers and fields
	// ------------------------------------------------------------
	logic [7:0]  cfg_a_q, cfg_b_q, cfg_c_q, mask_q, st_q, div_q, tcnt_q;
	logic [15:0] limit_q, base_q, avg_q, ldty_q, hdty_q;
	logic [16:0] cyc_q, low_q, high_q, thr;
	logic [4:0]  rep_q;
	logic [5:0]  nrun_q, nlim;
	logic        tick_q, nf_flag_q, irq_flag_q, seeded_q, last_q;
	logic        start_w, filt_on, noise_long, ign, bucket, touch, irq_ev;
	logic [15:0] base_now;
	logic [7:0]  settle_n, gap_n, ev;
	tsc_state_t  state_q;

	wire       auto_m   = cfg_a_q[CFGA_AUTO];
	wire [1:0] rpt_sel  = cfg_b_q[CFGB_RPT+:2];
	wire [1:0] ini_sel  = cfg_b_q[CFGB_INI+:2];
	wire [1:0] gap_sel  = cfg_b_q[CFGB_GAP+:2];
	wire [1:0] nf_sel   = cfg_b_q[CFGB_NF+:2];
	wire [1:0] avg_sel  = cfg_c_q[CFGC_AVG+:2];
	wire [2:0] cyc_sel  = cfg_c_q[CFGC_CYC+:3];
	wire       seed_sel = cfg_c_q[CFGC_SEED];
	wire       rel_sel  = cfg_c_q[CFGC_REL];
	wire       snf      = cfg_c_q[CFGC_SNF];
	wire       wr_ctrl  = reg_wr && reg_addr == ADDR_CTRL;

	function automatic logic [16:0] cyc_total(input logic [2:0] s);
		unique case (s)
			3'h0: cyc_total = 17'h00400;
			3'h1: cyc_total = 17'h00800;
			3'h2: cyc_total = 17'h01000;
			3'h3: cyc_total = 17'h02000;
			3'h4: cyc_total = 17'h03000;
			3'h5: cyc_total = 17'h04000;
			3'h6: cyc_total = 17'h08000;
			3'h7: cyc_total = 17'h10000;
		endcase
	endfunction

	function automatic logic [4:0] rpt_total(input logic [1:0] s);
		unique case (s)
			2'h0: rpt_total = 5'h01;
			2'h1: rpt_total = 5'h04;
			2'h2: rpt_total = 5'h08;
			2'h3: rpt_total = 5'h10;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Derived timing and decisions
	// ------------------------------------------------------------
	wire [16:0] ncyc = cyc_total(cyc_sel);

	always_comb begin
		settle_n   = ({6'h00, ini_sel} + 8'h01) * SETTLE_MULT;
		gap_n      = ({6'h00, gap_sel} + 8'h01) * GAP_MULT;
		nlim       = {4'h0, nf_sel} * NOISE_MULT;
		filt_on    = auto_m ? snf : 1'b1;
		noise_long = nf_sel != 2'h0 && fe_in.noise && nrun_q >= nlim;
		ign        = noise_long && filt_on;
		bucket     = ign ? last_q : fe_in.sample;
		base_now   = seeded_q ? avg_q : (seed_sel ? low_q[15:0] : base_q);
		thr        = rel_sel ? {1'b0, limit_q} + {1'b0, (auto_m ? base_now : base_q)}
		                     : {1'b0, limit_q};
		touch      = low_q > thr;
		irq_ev     = state_q == TSC_DONE && (!auto_m || touch);
		start_w    = wr_ctrl && reg_wdata[CTRL_START] && !auto_m;
		ev         = 8'h00;
		ev[IRQ_DONE]  = state_q == TSC_DONE;
		ev[IRQ_TOUCH] = irq_ev;
		ev[IRQ_NOISE] = state_q == TSC_CONV && tick_q && noise_long;
	end

	// ------------------------------------------------------------
	// Touch clock tick
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || div_q == 8'(TK_DIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
		tick_q <= !reset && div_q == 8'(TK_DIV - 1);
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= TSC_IDLE;
			tcnt_q  <= 8'h00;
			rep_q   <= 5'h00;
		end else begin
			unique case (state_q)
				TSC_IDLE: begin
					tcnt_q <= 8'h00;
					rep_q  <= 5'h00;
					if (auto_m) begin
						state_q <= TSC_GAP;
					end else if (start_w) begin
						state_q <= TSC_SETTLE;
					end
				end
				TSC_GAP: begin
					if (tick_q && tcnt_q == gap_n - 8'h01) begin
						state_q <= TSC_SETTLE;
						tcnt_q  <= 8'h00;
					end else if (tick_q) begin
						tcnt_q <= tcnt_q + 8'h01;
					end
				end
				TSC_SETTLE: begin
					if (tick_q && tcnt_q == settle_n - 8'h01) begin
						state_q <= TSC_CONV;
						tcnt_q  <= 8'h00;
					end else if (tick_q) begin
						tcnt_q <= tcnt_q + 8'h01;
					end
				end
				TSC_CONV: begin
					if (tick_q && cyc_q == ncyc - 17'h00001) begin
						rep_q   <= rep_q + 5'h01;
						state_q <= rep_q == rpt_total(rpt_sel) - 5'h01 ? TSC_DONE : TSC_SETTLE;
					end
				end
				TSC_DONE: state_q <= TSC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Conversion counters and noise run
	// ------------------------------------------------------------
	// Ignored ticks are booked to the last trusted sample so the two duty
	// counts always add up to the programmed cycle count.
	always_ff @(posedge sys_clk) begin
		if (reset || state_q != TSC_CONV) begin
			cyc_q  <= 17'h00000;
			nrun_q <= 6'h00;
			last_q <= 1'b0;
			if (reset || state_q == TSC_SETTLE) begin
				low_q  <= 17'h00000;
				high_q <= 17'h00000;
			end
		end else if (tick_q) begin
			cyc_q  <= cyc_q + 17'h00001;
			nrun_q <= !fe_in.noise ? 6'h00 : (nrun_q == 6'h3F ? nrun_q : nrun_q + 6'h01);
			last_q <= bucket;
			if (bucket) begin
				high_q <= high_q + 17'h00001;
			end else begin
				low_q <= low_q + 17'h00001;
			end
		end
	end

	// ------------------------------------------------------------
	// Results, baseline average and flags
	// ------------------------------------------------------------
	// A first-order average stands in for a true window; it needs no sample memory.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ldty_q   <= 16'h0000;
			hdty_q   <= 16'h0000;
			avg_q    <= 16'h0000;
			seeded_q <= 1'b0;
		end else if (!auto_m) begin
			seeded_q <= 1'b0;
			if (state_q == TSC_DONE) begin
				ldty_q <= low_q[15:0];
				hdty_q <= high_q[15:0];
			end
		end else if (state_q == TSC_DONE) begin
			ldty_q   <= low_q[15:0];
			hdty_q   <= high_q[15:0];
			seeded_q <= 1'b1;
			if (!seeded_q) begin
				avg_q <= base_now;
			end else begin
				avg_q <= avg_q + 16'(($signed({1'b0, low_q[15:0]}) - $signed({1'b0, avg_q}))
				         >>> (AVG_SH_BASE + {2'h0, avg_sel}));
			end
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nf_flag_q  <= 1'b0;
			irq_flag_q <= 1'b0;
		end else begin
			nf_flag_q  <= ev[IRQ_NOISE] || (nf_flag_q && !(wr_ctrl && !reg_wdata[CTRL_NFLG]));
			irq_flag_q <= irq_ev || (irq_flag_q && !(wr_ctrl && !reg_wdata[CTRL_IFLG]));
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_a_q <= REG_RESET;
			cfg_b_q <= REG_RESET;
			cfg_c_q <= REG_RESET;
			mask_q  <= REG_RESET;
			limit_q <= {REG_RESET, REG_RESET};
			base_q  <= {REG_RESET, REG_RESET};
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_CFG_A: cfg_a_q <= reg_wdata;
				ADDR_CFG_B: cfg_b_q <= reg_wdata;
				ADDR_CFG_C: cfg_c_q <= reg_wdata;
				ADDR_IMASK: mask_q <= reg_wdata;
				ADDR_LIM_L: limit_q[7:0] <= reg_wdata;
				ADDR_LIM_H: limit_q[15:8] <= reg_wdata;
				ADDR_BAS_L: base_q[7:0] <= reg_wdata;
				ADDR_BAS_H: base_q[15:8] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data, interrupt status and outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				ADDR_CFG_A: reg_rdata <= cfg_a_q;
				ADDR_CFG_B: reg_rdata <= cfg_b_q;
				ADDR_CFG_C: reg_rdata <= cfg_c_q;
				ADDR_CTRL:  reg_rdata <= {5'h00, irq_flag_q, nf_flag_q, state_q != TSC_IDLE};
				ADDR_ISTAT: reg_rdata <= st_q;
				ADDR_IMASK: reg_rdata <= mask_q;
				ADDR_LIM_L: reg_rdata <= limit_q[7:0];
				ADDR_LIM_H: reg_rdata <= limit_q[15:8];
				ADDR_BAS_L: reg_rdata <= base_q[7:0];
				ADDR_BAS_H: reg_rdata <= base_q[15:8];
				ADDR_LDT_L: reg_rdata <= ldty_q[7:0];
				ADDR_LDT_H: reg_rdata <= ldty_q[15:8];
				ADDR_HDT_L: reg_rdata <= hdty_q[7:0];
				ADDR_HDT_H: reg_rdata <= hdty_q[15:8];
				default:    reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q          <= REG_RESET;
			irq           <= 1'b0;
			wakeup        <= 1'b0;
			fe_out.settle <= 1'b0;
			fe_out.charge <= 1'b0;
		end else begin
			st_q          <= ((reg_rd && reg_addr == ADDR_ISTAT) ? 8'h00 : st_q) | ev;
			irq           <= |(st_q & mask_q);
			wakeup        <= auto_m && irq_ev;
			fe_out.settle <= state_q == TSC_SETTLE;
			fe_out.charge <= state_q == TSC_CONV;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	start_launch_a: assert property (start_w && state_q == TSC_IDLE |=> state_q == TSC_SETTLE)
		else $error("start write did not launch a sequence");
	done_irq_a: assert property (state_q == TSC_DONE && !auto_m |=> st_q[IRQ_TOUCH] && irq_flag_q)
		else $error("normal mode result gave no interrupt");
	settle_len_a: assert property ($rose(state_q == TSC_CONV) |-> $past(tcnt_q) == settle_n - 8'h01)
		else $error("settling delay length wrong");
	gap_len_a: assert property ($rose(state_q == TSC_SETTLE) && $past(state_q) == TSC_GAP
		|-> $past(tcnt_q) == gap_n - 8'h01 && auto_m)
		else $error("auto start gap length wrong");
	filter_off_a: assert property (nf_sel == 2'h0 || (auto_m && !snf) |-> !ign)
		else $error("noise ignored while filtering off");
	cycle_run_a: assert property (state_q == TSC_CONV && tick_q && ign && cyc_q != ncyc - 17'h00001
		|=> cyc_q == $past(cyc_q) + 17'h00001)
		else $error("cycle count paused during noise");
	duty_sum_a: assert property (state_q == TSC_DONE |-> {1'b0, low_q} + {1'b0, high_q} == {1'b0, ncyc})
		else $error("duty counts do not add to cycle count");
	noise_flag_a: assert property (ev[IRQ_NOISE] |=> nf_flag_q ##1 st_q[IRQ_NOISE] || $past(reg_rd))
		else $error("noise flag not raised");
	auto_wake_a: assert property (state_q == TSC_DONE && auto_m && low_q > thr |=> wakeup && irq_flag_q)
		else $error("touch above threshold gave no wakeup");
	rel_thr_a: assert property (auto_m && seeded_q && rel_sel |-> thr == {1'b0, limit_q} + {1'b0, avg_q})
		else $error("relative threshold wrong");
	irq_line_a: assert property ((st_q & mask_q) != 8'h00 |=> irq)
		else $error("unmasked status did not raise irq");
	auto_gap_a: assert property (state_q == TSC_IDLE && auto_m |=> state_q == TSC_GAP)
		else $error("auto mode did not start a gap");
	seed_load_a: assert property (state_q == TSC_DONE && auto_m && !seeded_q
		|=> avg_q == $past(base_now))
		else $error("moving average not seeded");
	wake_normal_a: assert property (!$past(auto_m) |-> !wakeup)
		else $error("wakeup raised in normal mode");
endmodule // tsc_top

// file: rtl/tsc_pkg.sv
// Package: register map, field layout and timing constants of the touch channel
package tsc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          AW         = 16;
	localparam logic [15:0] ADDR_CFG_A = 16'hA018;
	localparam logic [15:0] ADDR_CFG_B = 16'hA019;
	localparam logic [15:0] ADDR_CFG_C = 16'hA01A;
	localparam logic [15:0] ADDR_CTRL  = 16'hA020;
	localparam logic [15:0] ADDR_ISTAT = 16'hA021;
	localparam logic [15:0] ADDR_IMASK = 16'hA022;
	localparam logic [15:0] ADDR_LIM_L = 16'hA023;
	localparam logic [15:0] ADDR_LIM_H = 16'hA024;
	localparam logic [15:0] ADDR_BAS_L = 16'hA025;
	localparam logic [15:0] ADDR_BAS_H = 16'hA026;
	localparam logic [15:0] ADDR_LDT_L = 16'hA027;
	localparam logic [15:0] ADDR_LDT_H = 16'hA028;
	localparam logic [15:0] ADDR_HDT_L = 16'hA029;
	localparam logic [15:0] ADDR_HDT_H = 16'hA02A;
	localparam logic [7:0]  REG_RESET  = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFGA_AUTO  = 0;
	localparam int CFGB_RPT   = 6;
	localparam int CFGB_INI   = 4;
	localparam int CFGB_GAP   = 2;
	localparam int CFGB_NF    = 0;
	localparam int CFGC_AVG   = 6;
	localparam int CFGC_CYC   = 3;
	localparam int CFGC_SEED  = 2;
	localparam int CFGC_REL   = 1;
	localparam int CFGC_SNF   = 0;
	localparam int CTRL_START = 0;
	localparam int CTRL_NFLG  = 1;
	localparam int CTRL_IFLG  = 2;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_TOUCH  = 1;
	localparam int IRQ_NOISE  = 2;
	// ------------------------------------------------------------
	// Timing in touch-clock periods, average shift base, state and front-end types
	// ------------------------------------------------------------
	localparam logic [7:0] SETTLE_MULT = 8'h04;
	localparam logic [7:0] GAP_MULT    = 8'h02;
	localparam logic [5:0] NOISE_MULT  = 6'h08;
	localparam logic [3:0] AVG_SH_BASE = 4'h5;
	typedef enum logic [2:0] {TSC_IDLE, TSC_GAP, TSC_SETTLE, TSC_CONV, TSC_DONE} tsc_state_t;
	typedef struct packed {
		logic sample;
		logic noise;
	} tsc_fe_in_t;
	typedef struct packed {
		logic settle;
		logic charge;
	} tsc_fe_out_t;
endpackage

// file: tb/tsc_fe_model.sv
// Behavioural model of the electrode and charge-sharing front end
`timescale 1ns/10ps
module tsc_fe_model (
	// Clock
	input  wire logic                sys_clk,
	// Front end pins
	input  wire tsc_pkg::tsc_fe_out_t fe_out,
	output tsc_pkg::tsc_fe_in_t       fe_in,
	// Scenario controls
	input  wire logic                high_duty,
	input  wire logic                noise_on
);
	import tsc_pkg::*;

	initial fe_in = '0;

	// ------------------------------------------------------------
	// Comparator and noise detector
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		// Outside a conversion the comparator output is meaningless, so it toggles
		if (fe_out.charge === 1'b1)
			fe_in.sample <= high_duty;
		else
			fe_in.sample <= ~fe_in.sample;
		fe_in.noise <= noise_on;
	end
endmodule // tsc_fe_model

// file: tb/tb_top.sv
// Self-checking testbench of the touch channel block
`timescale 1ns/10ps
module tb_top;
	import tsc_pkg::*;
	localparam int TKD = 1;

	logic          sys_clk   = 1'b0;
	logic          reset     = 1'b1;
	logic [AW-1:0] reg_addr  = '0;
	logic [7:0]    reg_wdata = 8'h00;
	logic          reg_wr    = 1'b0;
	logic          reg_rd    = 1'b0;
	logic [7:0]    reg_rdata;
	tsc_fe_in_t    fe_in;
	tsc_fe_out_t   fe_out;
	logic          irq;
	logic          wakeup;
	logic          high_duty = 1'b0;
	logic          noise_on  = 1'b0;
	int            errors    = 0;
	int            compares  = 0;
	int            wake_cnt  = 0;
	logic [31:0]   seed      = 32'hB430;
	logic [7:0]    d;
	logic [16:0]   lo;
	logic [16:0]   sum;
	int            n;
	int            n0;
	int            n1;
	logic [15:0]   rw_addr [6] = '{ADDR_CFG_B, ADDR_CFG_C, ADDR_LIM_L, ADDR_LIM_H,
		ADDR_BAS_L, ADDR_BAS_H};

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (wakeup === 1'b1) wake_cnt++;

	tsc_top #(.TK_DIV(TKD)) u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fe_in(fe_in), .fe_out(fe_out), .irq(irq), .wakeup(wakeup));
	tsc_fe_model u_fe (.sys_clk(sys_clk), .fe_out(fe_out), .fe_in(fe_in),
		.high_duty(high_duty), .noise_on(noise_on));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
		rd(a, d);
		chk({24'h0, d}, {24'h0, exp});
	endtask
	// Polls busy, so the next start never lands on a running sequence
	task automatic wait_idle();
		for (int i = 0; i < 3000; i++) begin
			rd(ADDR_CTRL, d);
			if (d[CTRL_START] === 1'b0) break;
		end
		// A sequence that never ends is a failure, not a silent pass-through
		if (d[CTRL_START] !== 1'b0) errors++;
	endtask
	// Cycles until the settle phase shows, then its length in cycles
	task automatic meas_settle(output int w, output int cnt);
		w = 0;
		cnt = 0;
		while (fe_out.settle !== 1'b1 && w < 3000) begin
			@(posedge sys_clk);
			#1 w++;
		end
		while (fe_out.settle === 1'b1 && cnt < 3000) begin
			@(posedge sys_clk);
			#1 cnt++;
		end
	endtask
	task automatic duty(output logic [16:0] l, output logic [16:0] s);
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		rd(ADDR_LDT_L, a);
		rd(ADDR_LDT_H, b);
		rd(ADDR_HDT_L, c);
		rd(ADDR_HDT_H, d);
		l = {1'b0, b, a};
		s = l + {1'b0, d, c};
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int a = 0; a < 3; a++) chk_rd(ADDR_CFG_A + 16'(a), REG_RESET);
		wr(16'hA030, 8'h5A);
		chk_rd(16'hA030, 8'h00);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(rw_addr[i], seed[7:0]);
			chk_rd(rw_addr[i], seed[7:0]);
		end
		// Normal mode, every settling code, interrupt masked off
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_CFG_C, 8'h00);
		for (int ini = 0; ini < 4; ini++) begin
			seed = lfsr(seed);
			high_duty <= seed[0];
			wr(ADDR_CFG_B, {2'b00, 2'(ini), 4'h0});
			wr(ADDR_CTRL, 8'h01);
			meas_settle(n0, n);
			chk(32'(n), 32'((ini + 1) * SETTLE_MULT * TKD));
			wait_idle();
			duty(lo, sum);
			chk({15'h0, sum}, 32'h00000400);
			chk({31'h0, irq}, 32'h0);
			rd(ADDR_CTRL, d);
			chk({31'h0, d[CTRL_IFLG]}, 32'h1);
			wr(ADDR_CTRL, 8'h00);
		end
		wr(ADDR_IMASK, 8'h07);
		repeat (2) @(posedge sys_clk);
		#1 chk({31'h0, irq}, 32'h1);
		rd(ADDR_ISTAT, d);
		chk({31'h0, d[IRQ_DONE]}, 32'h1);
		repeat (2) @(posedge sys_clk);
		#1 chk({31'h0, irq}, 32'h0);
		chk_rd(ADDR_ISTAT, 8'h00);
		// Noise for the whole conversion: counting goes on, flag set
		wr(ADDR_CFG_B, 8'h01);
		noise_on  <= 1'b1;
		high_duty <= 1'b0;
		wr(ADDR_CTRL, 8'h01);
		// Comparator flips mid-conversion under noise: those ticks must be ignored
		repeat (300) @(posedge sys_clk);
		high_duty <= 1'b1;
		wait_idle();
		noise_on <= 1'b0;
		duty(lo, sum);
		chk({15'h0, sum}, 32'h00000400);
		chk({31'h0, lo > 17'h003E8}, 32'h1);
		rd(ADDR_CTRL, d);
		chk({31'h0, d[CTRL_NFLG]}, 32'h1);
		wr(ADDR_CTRL, 8'h00);
		chk_rd(ADDR_CTRL, 8'h00);
		// Auto mode, absolute limit below the low duty count
		high_duty <= 1'b0;
		wr(ADDR_CFG_B, 8'h00);
		wr(ADDR_LIM_L, 8'h00);
		wr(ADDR_LIM_H, 8'h03);
		wr(ADDR_BAS_L, 8'h00);
		wr(ADDR_BAS_H, 8'h02);
		rd(ADDR_ISTAT, d);
		wake_cnt = 0;
		wr(ADDR_CFG_A, 8'h01);
		meas_settle(n0, n);
		repeat (2500) @(posedge sys_clk);
		chk({31'h0, wake_cnt > 0}, 32'h1);
		rd(ADDR_ISTAT, d);
		chk({31'h0, d[IRQ_TOUCH]}, 32'h1);
		wr(ADDR_CFG_A, 8'h00);
		wait_idle();
		// Longest start gap against the shortest one
		wr(ADDR_CFG_B, 8'h0C);
		wr(ADDR_CFG_A, 8'h01);
		meas_settle(n, n1);
		chk(32'(n - n0), 32'(3 * GAP_MULT * TKD));
		wr(ADDR_CFG_A, 8'h00);
		wait_idle();
		// Relative limit: limit plus baseline lies above the low duty count
		wr(ADDR_CFG_C, 8'h02);
		wr(ADDR_CFG_B, 8'h00);
		wake_cnt = 0;
		wr(ADDR_CFG_A, 8'h01);
		repeat (3000) @(posedge sys_clk);
		chk(32'(wake_cnt), 32'h0);
		wr(ADDR_CFG_A, 8'h00);
		wait_idle();
		// Seed from the first result: a zero software baseline must not be used
		wr(ADDR_BAS_L, 8'h00);
		wr(ADDR_BAS_H, 8'h00);
		wr(ADDR_CFG_C, 8'h06);
		wake_cnt = 0;
		wr(ADDR_CFG_A, 8'h01);
		repeat (2500) @(posedge sys_clk);
		chk(32'(wake_cnt), 32'h0);
		wr(ADDR_CFG_A, 8'h00);
		wait_idle();
		end_sim();
	end
endmodule // tb_top
